// ===== design/sdram_lp_pkg.sv
// package: register map, fields, commands and states of the sdram low-power control
package sdram_lp_pkg;

  localparam logic [7:0]  OFS_MODE        = 8'h00;
  localparam logic [7:0]  OFS_REFRESH     = 8'h04;
  localparam logic [7:0]  OFS_CONFIG      = 8'h08;
  localparam logic [7:0]  OFS_DECODE      = 8'h0C;
  localparam logic [7:0]  OFS_LOW_POWER   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_DISABLE = 8'h18;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h20;
  localparam logic [7:0]  OFS_DEVICE_TYPE = 8'h24;

  localparam logic [31:0] CONFIG_RESET    = 32'h8523_72C0;

  // configuration fields
  localparam int          CAS_POS         = 5;
  localparam int          TRC_POS         = 12;
  localparam int          TRP_POS         = 16;
  localparam int          ACTIVE_TO_PRECHARGE_DELAY_POS        = 24;
  localparam int          TXSR_POS        = 28;

  // low-power register fields
  localparam int          LOW_POWER_SELECT_POS        = 0;
  localparam int          PARTIAL_ARRAY_REFRESH_POS        = 4;
  localparam int          TEMP_COMP_REFRESH_POS        = 8;
  localparam int          DS_POS          = 10;
  localparam int          TIMEOUT_POS     = 12;
  localparam logic [31:0] LOW_POWER_MASK  = 32'h0000_3F73;

  localparam logic [1:0]  LP_NONE         = 2'h0;
  localparam logic [1:0]  LP_SELF         = 2'h1;
  localparam logic [1:0]  LP_PDOWN        = 2'h2;
  localparam logic [1:0]  LP_DEEP         = 2'h3;

  // timeout field codes in clock cycles
  localparam logic [7:0]  TIMEOUT_0       = 8'h00;
  localparam logic [7:0]  TIMEOUT_1       = 8'h40;
  localparam logic [7:0]  TIMEOUT_2       = 8'h80;

  localparam logic [1:0]  DEV_LOW_POWER   = 2'h1;
  localparam logic [3:0]  LOAD_MODE_WAIT  = 4'h2;
  localparam int          IRQ_REFRESH_ERR = 0;

  typedef enum logic [2:0] {
    CM_NORMAL  = 3'h0,
    CM_NOP     = 3'h1,
    CM_PRE_ALL = 3'h2,
    CM_LMR     = 3'h3,
    CM_REFRESH = 3'h4,
    CM_EMR     = 3'h5,
    CM_DEEP    = 3'h6
  } cmd_mode_t;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_WAIT   = 3'b001,
    ST_PDOWN  = 3'b011,
    ST_SELF   = 3'b010,
    ST_DEEP   = 3'b110
  } lp_state_t;

  // {cs_n, ras_n, cas_n, we_n}
  typedef logic [3:0] sdram_cmd_t;
  localparam sdram_cmd_t CMD_NOP     = 4'h7;
  localparam sdram_cmd_t CMD_PRE     = 4'h2;
  localparam sdram_cmd_t CMD_REFRESH = 4'h1;
  localparam sdram_cmd_t CMD_LOAD    = 4'h0;
  localparam sdram_cmd_t CMD_DEEP    = 4'h6;

  typedef struct packed {
    logic        clock_enable_out;
    sdram_cmd_t  cmd;
    logic [1:0]  bank;
    logic [12:0] addr;
  } sdram_pins_t;

endpackage : sdram_lp_pkg

// ===== design/sdram_lp_ctrl.sv
// module: sdram low-power and command-mode controller with apb registers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module sdram_lp_ctrl (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      mem_req,
  output logic                           mem_ack,
  output logic                           normal_access,
  output sdram_lp_pkg::sdram_pins_t      pins,
  output logic                           memory_clock_run,
  output logic                           irq
);

  logic [2:0]              mode;
  logic [11:0]             refresh_count;
  logic                    refresh_armed;
  logic [11:0]             refresh_timer;
  logic                    refresh_due;
  logic [31:0]             config_word;
  logic                    decode_cycle;
  logic [31:0]             low_power;
  logic [1:0]              device_type;
  logic [31:0]             irq_mask;
  logic [31:0]             irq_status;
  logic                    init_done;
  logic                    emr_dirty;
  logic [7:0]              idle_cnt;
  logic [3:0]              wait_cnt;
  logic [3:0]              stay_cnt;
  sdram_lp_pkg::lp_state_t state;
  logic [31:0]             read_word;
  logic                    setup;
  logic                    take;
  logic                    wr;
  logic                    refresh_go;
  logic                    refresh_err;
  logic                    lp_enter;
  logic                    emr_issue;
  logic [1:0]              low_power_select;
  logic [7:0]              timeout;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= sdram_lp_pkg::OFS_DEVICE_TYPE);
  endfunction : mapped

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [3:0] cfg_field(input logic [31:0] c, input int pos);
    cfg_field = c[pos +: 4];
  endfunction : cfg_field

  function automatic sdram_lp_pkg::sdram_pins_t drive(input logic cke, input sdram_lp_pkg::sdram_cmd_t c,
                                                      input logic [1:0] b, input logic [12:0] a);
    drive = '{clock_enable_out: cke, cmd: c, bank: b, addr: a};
  endfunction : drive

  assign setup = psel && !penable;
  assign take  = psel && penable && pready;
  assign wr    = take && pwrite;
  assign low_power_select  = low_power[sdram_lp_pkg::LOW_POWER_SELECT_POS +: 2];

  always_comb begin
    case (low_power[sdram_lp_pkg::TIMEOUT_POS +: 2])
      2'h0:    timeout = sdram_lp_pkg::TIMEOUT_0;
      2'h1:    timeout = sdram_lp_pkg::TIMEOUT_1;
      default: timeout = sdram_lp_pkg::TIMEOUT_2;
    endcase
  end

  // automatic entry only after the timeout of idle cycles; select 0 blocks it, while command mode CM_DEEP enters without either
  assign lp_enter = !mem_req && (idle_cnt >= timeout) && (low_power_select != sdram_lp_pkg::LP_NONE);
  assign emr_issue = init_done && emr_dirty && (low_power_select == sdram_lp_pkg::LP_SELF);
  assign refresh_go = refresh_armed && refresh_due;

  always_comb begin
    read_word = 32'h0000_0000;
    case (paddr)
      sdram_lp_pkg::OFS_MODE:        read_word = {29'h0000_0000, mode};
      sdram_lp_pkg::OFS_REFRESH:     read_word = {20'h0_0000, refresh_count};
      sdram_lp_pkg::OFS_CONFIG:      read_word = config_word;
      sdram_lp_pkg::OFS_DECODE:      read_word = {31'h0000_0000, decode_cycle};
      sdram_lp_pkg::OFS_LOW_POWER:   read_word = low_power;
      sdram_lp_pkg::OFS_IRQ_MASK:    read_word = irq_mask;
      sdram_lp_pkg::OFS_IRQ_STATUS:  read_word = irq_status;
      sdram_lp_pkg::OFS_DEVICE_TYPE: read_word = {30'h0000_0000, device_type};
      default:                       read_word = 32'h0000_0000;
    endcase
  end

  // apb answer: data captured in setup, ready in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped(paddr);
      if (setup) begin
        prdata <= read_word;
      end
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (reset) begin
      mode         <= sdram_lp_pkg::CM_NORMAL;
      config_word  <= sdram_lp_pkg::CONFIG_RESET;
      decode_cycle <= 1'b0;
      low_power    <= 32'h0000_0000;
      device_type  <= 2'h0;
    end else if (wr) begin
      if (hit(paddr, sdram_lp_pkg::OFS_MODE)) begin
        mode <= pwdata[2:0];
      end
      if (hit(paddr, sdram_lp_pkg::OFS_CONFIG)) begin
        config_word <= pwdata;
      end
      if (hit(paddr, sdram_lp_pkg::OFS_DECODE)) begin
        decode_cycle <= pwdata[0];
      end
      if (hit(paddr, sdram_lp_pkg::OFS_LOW_POWER)) begin
        low_power <= pwdata & sdram_lp_pkg::LOW_POWER_MASK;
      end
      if (hit(paddr, sdram_lp_pkg::OFS_DEVICE_TYPE)) begin
        device_type <= pwdata[1:0];
      end
    end
  end

  // interrupt mask and sticky status, set wins over the read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask   <= 32'h0000_0000;
      irq_status <= 32'h0000_0000;
      irq        <= 1'b0;
    end else begin
      if (wr && hit(paddr, sdram_lp_pkg::OFS_IRQ_ENABLE)) begin
        irq_mask <= irq_mask | pwdata;
      end else if (wr && hit(paddr, sdram_lp_pkg::OFS_IRQ_DISABLE)) begin
        irq_mask <= irq_mask & ~pwdata;
      end
      irq_status <= (irq_status & ~((take && !pwrite && hit(paddr, sdram_lp_pkg::OFS_IRQ_STATUS)) ? prdata : 32'h0))
                    | {31'h0000_0000, refresh_err};
      irq <= |(irq_status & irq_mask);
    end
  end

  // refresh timer
  assign refresh_err = refresh_armed && (refresh_timer == 12'h000) && refresh_due;

  always_ff @(posedge clk) begin
    if (reset) begin
      refresh_count <= 12'h000;
      refresh_armed <= 1'b0;
      refresh_timer <= 12'h000;
    end else if (wr && hit(paddr, sdram_lp_pkg::OFS_REFRESH)) begin
      refresh_count <= pwdata[11:0];
      refresh_timer <= pwdata[11:0];
      refresh_armed <= 1'b1;
    end else if (refresh_armed) begin
      refresh_timer <= (refresh_timer == 12'h000) ? refresh_count : refresh_timer - 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      refresh_due <= 1'b0;
    end else if (refresh_armed && refresh_timer == 12'h000) begin
      refresh_due <= 1'b1;
    end else if (state == sdram_lp_pkg::ST_SELF) begin
      refresh_due <= 1'b0;
    end else if (state == sdram_lp_pkg::ST_ACTIVE && !(mem_req && !mem_ack) && refresh_go) begin
      refresh_due <= 1'b0;
    end
  end

  // extended mode fields changed since initialisation
  always_ff @(posedge clk) begin
    if (reset) begin
      emr_dirty <= 1'b0;
    end else if (wr && hit(paddr, sdram_lp_pkg::OFS_LOW_POWER) && init_done
                 && (pwdata[11:4] & 8'hF7) != low_power[11:4]) begin
      emr_dirty <= 1'b1;
    end else if (state == sdram_lp_pkg::ST_ACTIVE && !(mem_req && !mem_ack) && !refresh_go
                 && lp_enter && emr_issue) begin
      emr_dirty <= 1'b0;
    end else if (state == sdram_lp_pkg::ST_ACTIVE && mem_req && !mem_ack && mode == sdram_lp_pkg::CM_EMR) begin
      emr_dirty <= 1'b0;
    end
  end

  // idle cycles since the last access
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_cnt <= 8'h00;
    end else if (state != sdram_lp_pkg::ST_ACTIVE || mem_req) begin
      idle_cnt <= 8'h00;
    end else if (idle_cnt != 8'hFF) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // self-refresh residence counter
  always_ff @(posedge clk) begin
    if (reset) begin
      stay_cnt <= 4'h0;
    end else if (state != sdram_lp_pkg::ST_SELF) begin
      stay_cnt <= 4'h0;
    end else if (stay_cnt != 4'hF) begin
      stay_cnt <= stay_cnt + 4'h1;
    end
  end

  // command and power state machine
  always_ff @(posedge clk) begin
    if (reset) begin
      state            <= sdram_lp_pkg::ST_ACTIVE;
      pins             <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
      wait_cnt         <= 4'h0;
      mem_ack          <= 1'b0;
      normal_access    <= 1'b0;
      memory_clock_run <= 1'b1;
      init_done        <= 1'b0;
    end else begin
      mem_ack       <= 1'b0;
      normal_access <= 1'b0;
      case (state)
        sdram_lp_pkg::ST_ACTIVE: begin
          pins <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
          if (mem_req && !mem_ack) begin
            mem_ack <= 1'b1;
            case (mode)
              sdram_lp_pkg::CM_NORMAL: begin
                normal_access <= 1'b1;
                init_done     <= 1'b1;
              end
              sdram_lp_pkg::CM_NOP: begin
                pins <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
              end
              sdram_lp_pkg::CM_PRE_ALL: begin
                pins     <= drive(1'b1, sdram_lp_pkg::CMD_PRE, 2'h0, 13'h0400);
                wait_cnt <= cfg_field(config_word, sdram_lp_pkg::TRP_POS);
                state    <= sdram_lp_pkg::ST_WAIT;
              end
              sdram_lp_pkg::CM_LMR: begin
                pins     <= drive(1'b1, sdram_lp_pkg::CMD_LOAD, 2'h0,
                                  {6'h00, 1'b0, config_word[sdram_lp_pkg::CAS_POS +: 2], 4'h0});
                wait_cnt <= sdram_lp_pkg::LOAD_MODE_WAIT;
                state    <= sdram_lp_pkg::ST_WAIT;
              end
              sdram_lp_pkg::CM_REFRESH: begin
                pins     <= drive(1'b1, sdram_lp_pkg::CMD_REFRESH, 2'h0, 13'h0000);
                wait_cnt <= cfg_field(config_word, sdram_lp_pkg::TRC_POS);
                state    <= sdram_lp_pkg::ST_WAIT;
              end
              sdram_lp_pkg::CM_EMR: begin
                pins      <= drive(1'b1, sdram_lp_pkg::CMD_LOAD, 2'h2, {6'h00, low_power[11:8],
                                   low_power[6:4]});
                wait_cnt  <= sdram_lp_pkg::LOAD_MODE_WAIT;
                state     <= sdram_lp_pkg::ST_WAIT;
                init_done <= 1'b1;
              end
              sdram_lp_pkg::CM_DEEP: begin
                pins             <= drive(1'b0, sdram_lp_pkg::CMD_DEEP, 2'h0, 13'h0000);
                memory_clock_run <= 1'b0;
                init_done        <= 1'b0;
                state            <= sdram_lp_pkg::ST_DEEP;
              end
              default: begin
                pins <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
              end
            endcase
          end else if (refresh_go) begin
            pins     <= drive(1'b1, sdram_lp_pkg::CMD_REFRESH, 2'h0, 13'h0000);
            wait_cnt <= cfg_field(config_word, sdram_lp_pkg::TRC_POS);
            state    <= sdram_lp_pkg::ST_WAIT;
          end else if (lp_enter) begin
            case (low_power_select)
              sdram_lp_pkg::LP_SELF: begin
                if (emr_issue) begin
                  pins     <= drive(1'b1, sdram_lp_pkg::CMD_LOAD, 2'h2, {6'h00, low_power[11:8],
                                    low_power[6:4]});
                  wait_cnt <= sdram_lp_pkg::LOAD_MODE_WAIT;
                  state    <= sdram_lp_pkg::ST_WAIT;
                end else begin
                  pins             <= drive(1'b0, sdram_lp_pkg::CMD_REFRESH, 2'h0, 13'h0000);
                  memory_clock_run <= 1'b0;
                  state            <= sdram_lp_pkg::ST_SELF;
                end
              end
              sdram_lp_pkg::LP_PDOWN: begin
                pins  <= drive(1'b0, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
                state <= sdram_lp_pkg::ST_PDOWN;
              end
              default: begin
                if (device_type == sdram_lp_pkg::DEV_LOW_POWER) begin
                  pins             <= drive(1'b0, sdram_lp_pkg::CMD_DEEP, 2'h0, 13'h0000);
                  memory_clock_run <= 1'b0;
                  init_done        <= 1'b0;
                  state            <= sdram_lp_pkg::ST_DEEP;
                end
              end
            endcase
          end
        end
        sdram_lp_pkg::ST_WAIT: begin
          pins <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
          if (wait_cnt == 4'h0) begin
            state <= sdram_lp_pkg::ST_ACTIVE;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        sdram_lp_pkg::ST_SELF: begin
          pins <= drive(1'b0, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
          if ((mem_req || low_power_select != sdram_lp_pkg::LP_SELF)
              && stay_cnt >= cfg_field(config_word, sdram_lp_pkg::ACTIVE_TO_PRECHARGE_DELAY_POS)) begin
            pins             <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
            memory_clock_run <= 1'b1;
            wait_cnt         <= cfg_field(config_word, sdram_lp_pkg::TXSR_POS);
            state            <= sdram_lp_pkg::ST_WAIT;
          end
        end
        sdram_lp_pkg::ST_PDOWN: begin
          pins <= drive(1'b0, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
          if (mem_req || refresh_go || low_power_select != sdram_lp_pkg::LP_PDOWN) begin
            pins  <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
            state <= sdram_lp_pkg::ST_ACTIVE;
          end
        end
        sdram_lp_pkg::ST_DEEP: begin
          pins <= drive(1'b0, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
          // leaving only on access; contents must be rebuilt by software
          if (mem_req) begin
            pins             <= drive(1'b1, sdram_lp_pkg::CMD_NOP, 2'h0, 13'h0000);
            memory_clock_run <= 1'b1;
            state            <= sdram_lp_pkg::ST_ACTIVE;
          end
        end
        default: begin
          state <= sdram_lp_pkg::ST_ACTIVE;
        end
      endcase
    end
  end

endmodule : sdram_lp_ctrl

// ===== sim/sdram_lp_monitor.sv
// checker: port-level properties of the sdram low-power controller
`timescale 1ns/100ps
module sdram_lp_monitor (
  input logic                      clk,
  input logic                      reset,
  input logic                      psel,
  input logic                      penable,
  input logic                      pwrite,
  input logic [7:0]                paddr,
  input logic [31:0]               pwdata,
  input logic                      pready,
  input logic                      pslverr,
  input logic                      mem_ack,
  input logic                      normal_access,
  input sdram_lp_pkg::sdram_pins_t pins,
  input logic                      memory_clock_run
);
  logic [2:0]               mode;
  logic [31:0]              lp;
  logic [31:0]              cfg;
  logic [1:0]               dev;
  logic                     cke;
  sdram_lp_pkg::sdram_cmd_t cmd;
  assign cke = pins.clock_enable_out;
  assign cmd = pins.cmd;
  // shadow of the registers, updated at accepted writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= 3'h0;
      lp <= 32'h0000_0000;
      cfg <= sdram_lp_pkg::CONFIG_RESET;
      dev <= 2'h0;
    end else if (psel && penable && pwrite && pready && !pslverr) begin
      case (paddr)
        sdram_lp_pkg::OFS_MODE: mode <= pwdata[2:0];
        sdram_lp_pkg::OFS_LOW_POWER: lp <= pwdata & sdram_lp_pkg::LOW_POWER_MASK;
        sdram_lp_pkg::OFS_CONFIG: cfg <= pwdata;
        sdram_lp_pkg::OFS_DEVICE_TYPE: dev <= pwdata[1:0];
        default: ;
      endcase
    end
  end
  function automatic sdram_lp_pkg::sdram_cmd_t want(logic [2:0] m);
    case (m)
      3'h2: return sdram_lp_pkg::CMD_PRE;
      3'h3: return sdram_lp_pkg::CMD_LOAD;
      3'h4: return sdram_lp_pkg::CMD_REFRESH;
      3'h5: return sdram_lp_pkg::CMD_LOAD;
      3'h6: return sdram_lp_pkg::CMD_DEEP;
      default: return sdram_lp_pkg::CMD_NOP;
    endcase
  endfunction : want
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_self_entry;
    $fell(cke) && cmd == sdram_lp_pkg::CMD_REFRESH;
  endsequence
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_apb_error: assert property (pready |-> pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address");
  a_mode_command: assert property (mem_ack && mode != 3'h0 |-> cmd == want(mode))
    else $error("command does not match command mode");
  a_normal_hand: assert property (mem_ack |-> normal_access == (mode == 3'h0))
    else $error("normal hand-off wrong");
  a_lmr_value: assert property (mem_ack && mode == 3'h3 |-> pins.bank == 2'h0
    && pins.addr == {7'h00, cfg[6:5], 4'h0})
    else $error("mode register value wrong");
  a_emr_value: assert property (cmd == sdram_lp_pkg::CMD_LOAD && pins.bank == 2'h2
    |-> pins.addr == {6'h00, lp[11:8], lp[6:4]})
    else $error("extended mode value wrong");
  a_cke_cause: assert property ($fell(cke) |-> lp[1:0] != sdram_lp_pkg::LP_NONE || mode == 3'h6)
    else $error("clock enable fell with low power inhibited");
  a_self_stay: assert property (s_self_entry |-> (!cke)[*5])
    else $error("self-refresh left too early");
  a_self_quiet: assert property (!memory_clock_run && !$past(memory_clock_run)
    |-> cmd != sdram_lp_pkg::CMD_REFRESH)
    else $error("refresh issued in self-refresh");
  a_deep_cause: assert property (cmd == sdram_lp_pkg::CMD_DEEP
    |-> mode == 3'h6 || lp[1:0] == 2'h3 && dev == 2'h1)
    else $error("deep power-down without cause");
endmodule : sdram_lp_monitor
bind sdram_lp_ctrl sdram_lp_monitor u_mon (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .mem_ack, .normal_access, .pins, .memory_clock_run);

// ===== sim/sdram_model.sv
// partner: behavioural sdram that records the commands it receives
`timescale 1ns/100ps
module sdram_model (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire sdram_lp_pkg::sdram_pins_t pins,
  output sdram_lp_pkg::sdram_cmd_t       last_cmd,
  output logic [12:0]                    last_addr,
  output logic [12:0]                    emr_addr,
  output logic [7:0]                     refresh_cnt,
  output logic [7:0]                     load_cnt,
  output logic                           in_self
);
  always_ff @(posedge clk) begin
    if (reset) begin
      last_cmd <= sdram_lp_pkg::CMD_NOP;
      last_addr <= 13'h0000;
      emr_addr <= 13'h0000;
      refresh_cnt <= 8'h00;
      load_cnt <= 8'h00;
      in_self <= 1'b0;
    end else begin
      if (pins.cmd != sdram_lp_pkg::CMD_NOP) begin
        last_cmd <= pins.cmd;
        last_addr <= pins.addr;
      end
      if (pins.cmd == sdram_lp_pkg::CMD_LOAD && pins.bank == 2'h2) begin
        emr_addr <= pins.addr;
      end
      if (pins.cmd == sdram_lp_pkg::CMD_LOAD) begin
        load_cnt <= load_cnt + 8'h01;
      end
      // refresh with clock enable high is an auto-refresh, low is self-refresh entry
      if (pins.cmd == sdram_lp_pkg::CMD_REFRESH && pins.clock_enable_out) begin
        refresh_cnt <= refresh_cnt + 8'h01;
      end
      if (pins.cmd == sdram_lp_pkg::CMD_REFRESH && !pins.clock_enable_out) begin
        in_self <= 1'b1;
      end else if (pins.clock_enable_out) begin
        in_self <= 1'b0;
      end
    end
  end
endmodule : sdram_model

// ===== sim/sdram_lp_ctrl_tb.sv
// testbench: registers, command modes and low-power modes of the sdram controller
`timescale 1ns/100ps
module sdram_lp_ctrl_tb;
  logic                      clk, reset, psel, penable, pwrite, mem_req, pready, pslverr, mem_ack;
  logic                      normal_access, memory_clock_run, irq, in_self, ev, na;
  logic [7:0]                paddr, refresh_cnt, load_cnt, base;
  logic [31:0]               pwdata, prdata, rv, lpv, tv;
  logic [12:0]               last_addr, emr_addr;
  sdram_lp_pkg::sdram_pins_t pins;
  sdram_lp_pkg::sdram_cmd_t  last_cmd;
  int                        error_cnt, checked, lowc;
  logic [7:0]                ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [2:0]                seq [12] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h0};
  sdram_lp_ctrl uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_req, .mem_ack, .normal_access, .pins, .memory_clock_run, .irq);
  sdram_model u_mem (.clk, .reset, .pins, .last_cmd, .last_addr, .emr_addr, .refresh_cnt, .load_cnt, .in_self);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic acc();
    int n;
    n = 0;
    @(posedge clk);
    mem_req <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (mem_ack !== 1'b1 && n < 300);
    na = normal_access;
    chk("mem_ack", 1, mem_ack);
    mem_req <= 1'b0;
    @(posedge clk);
  endtask : acc
  function automatic sdram_lp_pkg::sdram_cmd_t exp_cmd(logic [2:0] m);
    if (m == 3'h2) return sdram_lp_pkg::CMD_PRE;
    if (m == 3'h4) return sdram_lp_pkg::CMD_REFRESH;
    if (m == 3'h6) return sdram_lp_pkg::CMD_DEEP;
    return sdram_lp_pkg::CMD_LOAD;
  endfunction : exp_cmd
  task automatic conclude();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    {reset, psel, penable, pwrite, mem_req, paddr, pwdata} = {5'h10, 8'h00, 32'h0000_0000};
    error_cnt = 0;
    checked = 0;
    rv = $urandom(32'h0000_CB17);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk("reset value", ofs[i] == 8'h08 ? sdram_lp_pkg::CONFIG_RESET : 32'h0000_0000, rv);
      chk("pslverr", ofs[i] == 8'h28, ev);
    end
    apb(1'b1, sdram_lp_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    apb(1'b0, sdram_lp_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    chk("mask set", 32'h0000_0001, rv);
    apb(1'b1, sdram_lp_pkg::OFS_IRQ_DISABLE, 32'h0000_0001);
    apb(1'b0, sdram_lp_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    chk("mask clear", 32'h0000_0000, rv);
    lpv = $urandom & 32'hFFFF_CFFC;
    apb(1'b1, sdram_lp_pkg::OFS_LOW_POWER, lpv);
    lpv = lpv & sdram_lp_pkg::LOW_POWER_MASK;
    apb(1'b0, sdram_lp_pkg::OFS_LOW_POWER, 32'h0000_0000);
    chk("low power readback", lpv, rv);
    foreach (seq[i]) begin
      apb(1'b1, sdram_lp_pkg::OFS_MODE, {29'h0, seq[i]});
      acc();
      chk("normal_access", seq[i] == 3'h0, na);
      if (seq[i] > 3'h1) chk("command", exp_cmd(seq[i]), last_cmd);
      if (seq[i] == 3'h3) chk("mode value", {7'h00, sdram_lp_pkg::CONFIG_RESET[6:5], 4'h0}, last_addr);
      if (seq[i] == 3'h5) chk("extended value", {6'h00, lpv[11:8], lpv[6:4]}, emr_addr);
    end
    base = refresh_cnt;
    repeat (100) @(posedge clk);
    chk("refresh before count", base, refresh_cnt);
    apb(1'b1, sdram_lp_pkg::OFS_LOW_POWER, lpv | 32'h0000_1002);
    acc();
    repeat (40) @(posedge clk);
    chk("cke before timeout", 1, pins.clock_enable_out);
    repeat (40) @(posedge clk);
    chk("cke after timeout", 0, pins.clock_enable_out);
    tv = $urandom_range(60, 30);
    apb(1'b1, sdram_lp_pkg::OFS_REFRESH, tv);
    apb(1'b0, sdram_lp_pkg::OFS_REFRESH, 32'h0000_0000);
    chk("refresh readback", tv, rv);
    apb(1'b1, sdram_lp_pkg::OFS_LOW_POWER, lpv | 32'h0000_0002);
    base = refresh_cnt;
    lowc = 0;
    repeat (400) begin
      @(posedge clk);
      lowc += !pins.clock_enable_out;
    end
    chk("refresh bursts", 1, refresh_cnt - base >= 400 / (2 * tv));
    chk("power-down share", 1, lowc > 200);
    lpv = lpv ^ 32'h0000_0010;
    base = load_cnt;
    apb(1'b1, sdram_lp_pkg::OFS_LOW_POWER, lpv | 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk("self entry", 1, in_self);
    chk("memory clock", 0, memory_clock_run);
    chk("extended rewrite", base + 8'h01, load_cnt);
    chk("extended rewrite value", {6'h00, lpv[11:8], lpv[6:4]}, emr_addr);
    acc();
    chk("access after self", 1, na);
    apb(1'b1, sdram_lp_pkg::OFS_LOW_POWER, lpv | 32'h0000_0003);
    repeat (20) @(posedge clk);
    lowc = 0;
    repeat (40) begin
      @(posedge clk);
      lowc += !pins.clock_enable_out;
    end
    chk("deep needs device type", 0, lowc);
    apb(1'b1, sdram_lp_pkg::OFS_DEVICE_TYPE, 32'h0000_0001);
    repeat (20) @(posedge clk);
    chk("deep command", sdram_lp_pkg::CMD_DEEP, last_cmd);
    chk("deep cke", 0, pins.clock_enable_out);
    repeat (130) @(posedge clk);
    chk("irq while masked", 0, irq);
    apb(1'b1, sdram_lp_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    apb(1'b0, sdram_lp_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk("refresh error flag", 1, rv[0]);
    conclude();
  end
endmodule : sdram_lp_ctrl_tb
